// [src/dhi_pkg.sv]
// Constants shared by the display host port and its helpers.
// Assumes a single 125 MHz clock domain on the device side.
package dhi_pkg;

	// Interface modes decoded from the port-select straps
	typedef enum logic [1:0] {
		MODE_NONE   = 2'b00,
		MODE_SERIAL = 2'b01,
		MODE_I8080  = 2'b10,
		MODE_M6800  = 2'b11
	} dhi_mode_e;

	// Strap codes, bit 2 down to bit 0
	localparam logic [2:0] STRAP_SERIAL = 3'h0;
	localparam logic [2:0] STRAP_I8080  = 3'h6;
	localparam logic [2:0] STRAP_M6800  = 3'h4;

	// Positions inside the synchronised pin vector
	localparam int PIN_W         = 15;
	localparam int PIN_STRAP_LSB = 12;
	localparam int PIN_CS        = 11;
	localparam int PIN_DC        = 10;
	localparam int PIN_E         = 9;
	localparam int PIN_RW        = 8;

	// Serial pins share data bits
	localparam int SER_CLK_BIT = 0;
	localparam int SER_DIN_BIT = 1;
	localparam logic [2:0] SER_LAST = 3'h7;

	// Command opcodes understood by the decoder
	localparam logic [7:0] OP_COL_ADDR   = 8'h15;
	localparam logic [7:0] OP_START_LINE = 8'hA1;
	localparam logic [7:0] OP_CONTRAST   = 8'h81;
	localparam logic [7:0] OP_DISP_OFF   = 8'hAE;
	localparam logic [7:0] OP_DISP_ON    = 8'hAF;

	// Power-on values
	localparam logic [6:0] RST_CONTRAST  = 7'h40;
	localparam logic [6:0] RST_START     = 7'h00;
	localparam logic [5:0] RST_COL       = 6'h00;
	localparam logic [5:0] RST_COL_END   = 6'h3F;
	localparam logic [7:0] RST_BYTE      = 8'h00;

endpackage : dhi_pkg

// [src/dhi_sync.sv]
// Two-stage synchroniser for a bundle of asynchronous pins.
// Assumes each bit is an independent level; the first stage feeds only the second.
`timescale 1ns/10ps
module dhi_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input  wire logic             mclk_i,
	input  wire logic             rst_b_i,
	// Pins in, synchronised levels out
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);

	logic [WIDTH-1:0] meta; // First stage, read only by the second

	// Two flip-flops in series
	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			meta   <= '0;
			sync_o <= '0;
		end else begin
			meta   <= async_i;
			sync_o <= meta;
		end
	end

endmodule : dhi_sync

// [src/dhi_cmd_dec.sv]
// Command decoder: turns command bytes and their parameters into settings.
// Assumes one-cycle strobes from the host port on the same clock.
`timescale 1ns/10ps
module dhi_cmd_dec (
	// Clock and reset
	input  wire logic       mclk_i,
	input  wire logic       rst_b_i,
	// Byte strobes from the host port
	input  wire logic       cmd_wr_i,
	input  wire logic [7:0] cmd_byte_i,
	input  wire logic       mem_wr_i,
	// Decoded settings
	output logic            display_on_o,
	output logic      [6:0] start_line_o,
	output logic      [5:0] col_addr_o,
	output logic      [6:0] contrast_o
);
	import dhi_pkg::*;

	// Which parameter byte is expected next
	typedef enum logic [2:0] {
		PAR_NONE  = 3'b000,
		PAR_START = 3'b001,
		PAR_COL_S = 3'b010,
		PAR_COL_E = 3'b011,
		PAR_CONTR = 3'b100
	} dhi_par_e;

	dhi_par_e   par;     // Pending parameter
	logic [5:0] col_beg; // Column window start
	logic [5:0] col_end; // Column window end

	// Opcode and parameter sequencing
	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			par          <= PAR_NONE;
			display_on_o <= 1'b0;
			start_line_o <= RST_START;
			contrast_o   <= RST_CONTRAST;
			col_beg      <= RST_COL;
			col_end      <= RST_COL_END;
		end else if (cmd_wr_i) begin
			unique case (par)
				// Parameter bytes load the matching setting
				PAR_START: begin
					start_line_o <= cmd_byte_i[6:0];
					par          <= PAR_NONE;
				end
				PAR_COL_S: begin
					col_beg <= cmd_byte_i[5:0];
					par     <= PAR_COL_E;
				end
				PAR_COL_E: begin
					col_end <= cmd_byte_i[5:0];
					par     <= PAR_NONE;
				end
				PAR_CONTR: begin
					contrast_o <= cmd_byte_i[6:0];
					par        <= PAR_NONE;
				end
				// Opcode byte
				PAR_NONE: begin
					if (cmd_byte_i == OP_START_LINE) begin
						par <= PAR_START;
					end else if (cmd_byte_i == OP_COL_ADDR) begin
						par <= PAR_COL_S;
					end else if (cmd_byte_i == OP_CONTRAST) begin
						par <= PAR_CONTR;
					end else if (cmd_byte_i == OP_DISP_ON) begin
						display_on_o <= 1'b1;
					end else if (cmd_byte_i == OP_DISP_OFF) begin
						display_on_o <= 1'b0;
					end
				end
				default: begin
					par <= PAR_NONE;
				end
			endcase
		end
	end

	// Column counter: reloads on the column command, steps on data writes
	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			col_addr_o <= RST_COL;
		end else if (cmd_wr_i && par == PAR_COL_S) begin
			col_addr_o <= cmd_byte_i[5:0];
		end else if (mem_wr_i) begin
			col_addr_o <= (col_addr_o == col_end) ? col_beg : col_addr_o + 6'h01;
		end
	end

endmodule : dhi_cmd_dec

// [src/dhi_host_port.sv]
// Host port of the display controller: 6800, 8080 and serial byte capture.
// Assumes all host pins are asynchronous to mclk_i and slower than 1/4 of it.
// Summary of operation
// - Straps decode to serial, 8080 or 6800.
// - Transfers happen only while chip select low.
// - 6800 read/write line: low write, high read.
// - Data/command line: low command, high data.
// - 6800 captures on falling latch pulse edge.
// - One dummy read before first memory read.
// - 8080 read completes on read strobe rise.
// - 8080 write latches on write strobe rise.
// - Form 2: chip select rise latches transfer.
// - Serial clock on bit 0, data bit 1.
// - Serial shifts MSB first on clock rise.
// - Eighth edge samples D/C and writes byte.
// - Serial mode is write only.
// - Data bytes to memory, commands to decoder.
// - Reset low initialises the device.
// - Reset: display off, counters zero, contrast 40h.
`timescale 1ns/10ps
module dhi_host_port (
	// Clock and reset (reset is the chip init pin)
	input  wire logic             mclk_i,
	input  wire logic             rst_b_i,
	// Interface select straps
	input  wire logic [2:0]       host_port_select_i,
	// Host control pins
	input  wire logic             cs_n_i,
	input  wire logic             dc_i,
	input  wire logic             e_rd_n_i,
	input  wire logic             rw_wr_n_i,
	// Host data bus, split three ways
	input  wire logic [7:0]       data_i,
	output logic      [7:0]       data_o,
	output logic                  data_oe_o,
	// Frame memory side
	output logic                  mem_wr_o,
	output logic      [7:0]       mem_wdata_o,
	output logic                  mem_rd_o,
	input  wire logic [7:0]       mem_rdata_i,
	// Status byte returned on command reads
	input  wire logic [7:0]       status_i,
	// Command side
	output logic                  cmd_wr_o,
	output logic      [7:0]       cmd_byte_o,
	output logic                  display_on_o,
	output logic      [6:0]       start_line_o,
	output logic      [5:0]       col_addr_o,
	output logic      [6:0]       contrast_o,
	// Decoded interface mode
	output dhi_pkg::dhi_mode_e    mode_o
);
	import dhi_pkg::*;

	// Strap decode
	function automatic dhi_mode_e strap_mode(input logic [2:0] s);
		if (s == STRAP_SERIAL) begin
			strap_mode = MODE_SERIAL;
		end else if (s == STRAP_I8080) begin
			strap_mode = MODE_I8080;
		end else if (s == STRAP_M6800) begin
			strap_mode = MODE_M6800;
		end else begin
			strap_mode = MODE_NONE;
		end
	endfunction : strap_mode

	// Rising edge between previous and present level
	function automatic logic rose_at(input logic prev, input logic now);
		rose_at = !prev && now;
	endfunction : rose_at

	logic [PIN_W-1:0] pin_s;    // Synchronised pins
	logic [2:0]       strap_s;  // Synchronised straps
	logic             cs_s;     // Chip select, low active
	logic             dc_s;     // Data/command level
	logic             e_s;      // Latch pulse or read strobe
	logic             rw_s;     // Read/write or write strobe
	logic [7:0]       bus_s;    // Data bus levels
	logic             sclk_s;   // Serial clock
	logic             serial_in_line_s;   // Serial data

	logic             cs_p;     // Previous levels for edge finding
	logic             e_p;
	logic             rw_p;
	logic             sclk_p;

	logic [7:0]       ser_shift; // Serial shift register
	logic [2:0]       ser_cnt;   // Bits taken in this byte
	logic [7:0]       rd_pipe;   // Prefetched memory byte

	logic             ev_wr;    // A byte arrives this cycle
	logic             ev_rd;    // A read completes this cycle
	logic             ev_dc;    // Its data/command level
	logic [7:0]       ev_byte;  // Its byte
	logic             rd_sel;   // A selected read is on the bus

	// All pins pass two flip-flops first
	dhi_sync #(
		.WIDTH (PIN_W)
	) u_sync (
		.mclk_i  (mclk_i),
		.rst_b_i (rst_b_i),
		.async_i ({host_port_select_i, cs_n_i, dc_i, e_rd_n_i, rw_wr_n_i, data_i}),
		.sync_o  (pin_s)
	);

	// Field slices of the synchronised vector
	assign strap_s = pin_s[PIN_STRAP_LSB +: 3];
	assign cs_s    = pin_s[PIN_CS];
	assign dc_s    = pin_s[PIN_DC];
	assign e_s     = pin_s[PIN_E];
	assign rw_s    = pin_s[PIN_RW];
	assign bus_s   = pin_s[7:0];
	assign sclk_s  = bus_s[SER_CLK_BIT];
	assign serial_in_line_s  = bus_s[SER_DIN_BIT];

	// Mode follows the straps; software has no say
	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			mode_o <= MODE_NONE;
		end else begin
			mode_o <= strap_mode(strap_s);
		end
	end

	// Previous levels for edge detection
	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			cs_p   <= 1'b1;
			e_p    <= 1'b0;
			rw_p   <= 1'b1;
			sclk_p <= 1'b0;
		end else begin
			cs_p   <= cs_s;
			e_p    <= e_s;
			rw_p   <= rw_s;
			sclk_p <= sclk_s;
		end
	end

	// Serial shift register and bit counter
	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			ser_shift <= RST_BYTE;
			ser_cnt   <= 3'h0;
		end else if (mode_o != MODE_SERIAL || cs_s) begin
			ser_cnt <= 3'h0;
		end else if (rose_at(sclk_p, sclk_s)) begin
			ser_shift <= {ser_shift[6:0], serial_in_line_s};
			ser_cnt   <= ser_cnt + 3'h1;
		end
	end

	// Transfer events for the three modes
	always_comb begin
		ev_wr   = 1'b0;
		ev_rd   = 1'b0;
		ev_dc   = dc_s;
		ev_byte = bus_s;
		unique case (mode_o)
			// Falling latch pulse with chip select low
			MODE_M6800: begin
				if (e_p && !e_s && !cs_s) begin
					ev_wr = !rw_s;
					ev_rd = rw_s;
				end
			end
			// Strobe rise (form 1) or chip select rise (form 2)
			MODE_I8080: begin
				if (rose_at(rw_p, rw_s) && !cs_s && e_s) begin
					ev_wr = 1'b1;
				end else if (rose_at(e_p, e_s) && !cs_s && rw_s) begin
					ev_rd = 1'b1;
				end else if (rose_at(cs_p, cs_s)) begin
					ev_wr = !rw_s && e_s;
					ev_rd = !e_s && rw_s;
				end
			end
			// Eighth serial clock rise completes a byte
			MODE_SERIAL: begin
				if (rose_at(sclk_p, sclk_s) && !cs_s && ser_cnt == SER_LAST) begin
					ev_wr   = 1'b1;
					ev_byte = {ser_shift[6:0], serial_in_line_s};
				end
			end
			MODE_NONE: begin
				ev_wr = 1'b0;
			end
		endcase
	end

	// Route each written byte to memory or to the command decoder
	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			mem_wr_o    <= 1'b0;
			cmd_wr_o    <= 1'b0;
			mem_wdata_o <= RST_BYTE;
			cmd_byte_o  <= RST_BYTE;
		end else begin
			mem_wr_o <= ev_wr && ev_dc;
			cmd_wr_o <= ev_wr && !ev_dc;
			if (ev_wr && ev_dc) begin
				mem_wdata_o <= ev_byte;
			end
			if (ev_wr && !ev_dc) begin
				cmd_byte_o <= ev_byte;
			end
		end
	end

	// Read pipeline: each data read fetches the byte for the next one
	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			mem_rd_o <= 1'b0;
			rd_pipe  <= RST_BYTE;
		end else begin
			mem_rd_o <= ev_rd && ev_dc && mode_o != MODE_SERIAL;
			if (mem_rd_o) begin
				rd_pipe <= mem_rdata_i;
			end
		end
	end

	// A read is on the bus while selected and the strobe is active
	always_comb begin
		unique case (mode_o)
			MODE_M6800: rd_sel = !cs_s && rw_s && e_s;
			MODE_I8080: rd_sel = !cs_s && !e_s && rw_s;
			MODE_SERIAL: rd_sel = 1'b0;
			MODE_NONE: rd_sel = 1'b0;
		endcase
	end

	// Bus drive: status on command reads, prefetched byte on data reads
	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			data_oe_o <= 1'b0;
			data_o    <= RST_BYTE;
		end else begin
			data_oe_o <= rd_sel;
			if (rd_sel) begin
				data_o <= dc_s ? rd_pipe : status_i;
			end else begin
				data_o <= RST_BYTE;
			end
		end
	end

	// Command decoding and display settings
	dhi_cmd_dec u_cmd (
		.mclk_i       (mclk_i),
		.rst_b_i      (rst_b_i),
		.cmd_wr_i     (cmd_wr_o),
		.cmd_byte_i   (cmd_byte_o),
		.mem_wr_i     (mem_wr_o),
		.display_on_o (display_on_o),
		.start_line_o (start_line_o),
		.col_addr_o   (col_addr_o),
		.contrast_o   (contrast_o)
	);

	// Checks on the transfer logic
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_b_i);

	a_strap_to_mode: assert property (
		(strap_s == STRAP_I8080) ##1 (strap_s == STRAP_I8080) |-> mode_o == MODE_I8080
	) else $error("straps did not select the 8080 mode");

	a_cs_blocks_writes: assert property (
		$past(cs_s, 2) && $past(cs_s) |-> !mem_wr_o && !cmd_wr_o
	) else $error("write issued while chip select was high");

	a_byte_routing: assert property (
		ev_wr && !ev_dc |=> cmd_wr_o && !mem_wr_o && cmd_byte_o == $past(ev_byte)
	) else $error("command byte not routed to decoder");

	a_latch_fall_write: assert property (
		mode_o == MODE_M6800 && $fell(e_s) && !cs_s && !rw_s && dc_s
		|=> mem_wr_o && mem_wdata_o == $past(bus_s)
	) else $error("6800 write not captured on falling latch pulse");

	a_strobe_rise_read: assert property (
		mode_o == MODE_I8080 && $rose(e_s) && !cs_s && rw_s && dc_s |=> mem_rd_o ##1 rd_pipe == $past(mem_rdata_i)
	) else $error("8080 data read did not advance the pipeline");

	a_strobe_rise_write: assert property (
		mode_o == MODE_I8080 && $rose(rw_s) && !cs_s && e_s && !dc_s |=> cmd_wr_o
	) else $error("8080 command write missed");

	a_cs_rise_latch: assert property (
		mode_o == MODE_I8080 && $rose(cs_s) && !rw_s && e_s && dc_s |=> mem_wr_o
	) else $error("form 2 write not latched on chip select rise");

	a_serial_byte: assert property (
		mode_o == MODE_SERIAL && $rose(sclk_s) && !cs_s && ser_cnt == SER_LAST && dc_s
		|=> mem_wr_o && mem_wdata_o == {$past(ser_shift[6:0]), $past(serial_in_line_s)}
	) else $error("serial byte not written on eighth clock");

	a_serial_no_read: assert property (
		$past(mode_o) == MODE_SERIAL |-> !data_oe_o && !mem_rd_o
	) else $error("read path active in serial mode");

	a_bus_release: assert property (
		$past(cs_s) |-> !data_oe_o
	) else $error("data bus driven while deselected");

	a_reset_values: assert property (
		$past(!rst_b_i) |-> !display_on_o && contrast_o == RST_CONTRAST && col_addr_o == RST_COL
		&& start_line_o == RST_START && ser_shift == RST_BYTE
	) else $error("power-on state wrong after reset");

endmodule : dhi_host_port

// [tb/dhi_host_model.sv]
// Host microcontroller model for the display host port.
// Assumes the bench resolves the shared data bus and returns it on bus_i.
`timescale 1ns/10ps
module dhi_host_model (
	// Pacing clock
	input  wire logic       mclk_i,
	// Resolved data bus
	input  wire logic [7:0] bus_i,
	// Pins towards the device
	output logic            cs_n_o,
	output logic            dc_o,
	output logic            e_rd_n_o,
	output logic            rw_wr_n_o,
	output logic      [7:0] data_o,
	output logic            drv_o
);
	// Wait whole cycles; pins change at falling edges
	task automatic gap(input int n);
		repeat (n) @(negedge mclk_i);
	endtask : gap

	// Idle levels: 6800 E low, 8080 strobes high, serial pins tied low
	task automatic idle(input logic m6800, input logic ser);
		cs_n_o = 1'b1;
		e_rd_n_o = !(m6800 || ser);
		rw_wr_n_o = !ser;
		data_o = ser ? 8'h00 : ~data_o; // Released bus shows the inverse
		drv_o = 1'b0;
	endtask : idle

	// One parallel transfer; f2 latches on chip select rise
	task automatic par(input logic m6800, input logic f2, input logic wr, input logic dc,
			input logic [7:0] b, output logic [7:0] q);
		dc_o = dc;
		if (m6800) rw_wr_n_o = !wr;
		if (f2 && wr) rw_wr_n_o = 1'b0;
		if (f2 && !wr) e_rd_n_o = 1'b0;
		if (!f2) cs_n_o = 1'b0;
		data_o = wr ? b : ~data_o;
		drv_o = wr;
		gap(5);
		// Strobe phase
		if (m6800) e_rd_n_o = 1'b1;
		else if (f2) cs_n_o = 1'b0;
		else if (wr) rw_wr_n_o = 1'b0;
		else e_rd_n_o = 1'b0;
		gap(6);
		q = bus_i;
		// Latching edge
		if (m6800) e_rd_n_o = 1'b0;
		else if (f2) cs_n_o = 1'b1;
		else begin
			e_rd_n_o = 1'b1;
			rw_wr_n_o = 1'b1;
		end
		gap(5);
		idle(m6800, 1'b0);
		gap(3);
	endtask : par

	// 6800 data write pulse with chip select left high; the device must ignore it
	task automatic stray;
		dc_o = 1'b1;
		rw_wr_n_o = 1'b0;
		gap(5);
		e_rd_n_o = 1'b1;
		gap(5);
		e_rd_n_o = 1'b0; // Falling latch edge while deselected
		gap(5);
		rw_wr_n_o = 1'b1;
		gap(3);
	endtask : stray

	// Serial write of n bits, MSB first; serial mode has no reads
	task automatic ser(input logic dc, input logic [7:0] b, input int n);
		cs_n_o = 1'b0;
		dc_o = dc;
		drv_o = 1'b1;
		for (int i = 7; i > 7 - n; i--) begin
			data_o = {6'h00, b[i], 1'b0};
			gap(5);
			data_o[0] = 1'b1;
			gap(5);
		end
		data_o[0] = 1'b0; // Serial clock stands low between frames
		gap(5);
		idle(1'b0, 1'b1);
		gap(3);
	endtask : ser

	// Start released, with 8080 idle levels
	initial begin
		data_o = 8'h00;
		dc_o = 1'b0;
		idle(1'b0, 1'b0);
	end
endmodule : dhi_host_model

// [tb/display_host_interface_bench.sv]
// Self-checking bench for the display host port.
// Assumes the host model in dhi_host_model.sv drives the pins.
`timescale 1ns/10ps
module display_host_interface_bench;
	import dhi_pkg::*;
	localparam logic HI = 1'b1; // Short flag literals
	localparam logic LO = 1'b0;
	logic       mclk, rst_b, cs_n, dc, e_rd_n, rw_wr_n, host_drv, data_oe;
	logic       mem_wr, mem_rd, cmd_wr, display_on;
	logic [2:0] host_port_select;
	logic [7:0] host_d, data_bus, dev_data, mem_wdata, mem_rdata, status, cmd_byte, last_mem;
	logic [6:0] start_line, contrast;
	logic [5:0] col_addr;
	dhi_mode_e  mode;
	int         mismatches, n_checks, n_mem_wr, n_cmd_wr, n_mem_rd;

	// Device drives the bus on reads, otherwise the host side
	assign data_bus = data_oe ? dev_data : host_d;

	dhi_host_model host (.mclk_i(mclk), .bus_i(data_bus), .cs_n_o(cs_n), .dc_o(dc),
		.e_rd_n_o(e_rd_n), .rw_wr_n_o(rw_wr_n), .data_o(host_d), .drv_o(host_drv));

	dhi_host_port uut (.mclk_i(mclk), .rst_b_i(rst_b), .host_port_select_i(host_port_select),
		.cs_n_i(cs_n), .dc_i(dc), .e_rd_n_i(e_rd_n), .rw_wr_n_i(rw_wr_n), .data_i(data_bus),
		.data_o(dev_data), .data_oe_o(data_oe), .mem_wr_o(mem_wr), .mem_wdata_o(mem_wdata),
		.mem_rd_o(mem_rd), .mem_rdata_i(mem_rdata), .status_i(status), .cmd_wr_o(cmd_wr),
		.cmd_byte_o(cmd_byte), .display_on_o(display_on), .start_line_o(start_line),
		.col_addr_o(col_addr), .contrast_o(contrast), .mode_o(mode));

	// Clock
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	// Count strobes, keep last memory byte, catch bus fights
	always @(posedge mclk) begin
		if (mem_wr) last_mem = mem_wdata;
		n_mem_wr += int'(mem_wr);
		n_cmd_wr += int'(cmd_wr);
		n_mem_rd += int'(mem_rd);
		if (data_oe === 1'b1 && host_drv) begin
			mismatches++;
			$display("[ERR] %0t bus contention", $time);
		end
	end

	// Frame memory stand-in: holds the last data byte, updated off the sampling edge
	always @(negedge mclk) begin
		if (mem_wr === 1'b1) mem_rdata <= mem_wdata;
	end

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic results;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : results

	// Reset for 3 cycles, then power-on values
	task automatic t_reset;
		rst_b = 1'b0;
		host.gap(3);
		rst_b = 1'b1;
		host.gap(4);
		check(8'(contrast), 8'h40);
		check(8'(display_on), 8'h00);
		check(8'(start_line), 8'h00);
		check(8'(col_addr), 8'h00);
		check(8'(data_oe), 8'h00);
	endtask : t_reset

	// Every strap code
	task automatic t_modes;
		dhi_mode_e exp;
		for (int s = 0; s < 8; s++) begin
			host_port_select = 3'(s);
			host.gap(5);
			exp = (s == 0) ? MODE_SERIAL : (s == 6) ? MODE_I8080 :
				(s == 4) ? MODE_M6800 : MODE_NONE;
			check(8'(mode), 8'(exp));
		end
	endtask : t_modes

	// 6800: deselected edge, writes, status and pipelined data reads
	task automatic t_6800;
		logic [7:0] q;
		int w, c, r;
		w = n_mem_wr;
		c = n_cmd_wr;
		r = n_mem_rd;
		host_port_select = 3'h4;
		host.idle(HI, LO);
		host.gap(8);
		host.stray;
		check(8'(n_mem_wr + n_cmd_wr + n_mem_rd - w - c - r), 8'h00);
		host.par(HI, LO, HI, HI, 8'hA5, q);
		check(last_mem, 8'hA5);
		check(8'(n_mem_wr - w), 8'h01);
		host.par(HI, LO, HI, LO, 8'hAF, q);
		check(cmd_byte, 8'hAF);
		check(8'(display_on), 8'h01);
		check(8'(n_cmd_wr - c), 8'h01);
		host.par(HI, LO, LO, LO, 8'h00, q);
		check(q, status);
		check(8'(n_mem_rd - r), 8'h00);
		host.par(HI, LO, LO, HI, 8'h00, q); // Dummy read shows the reset pipeline
		check(q, 8'h00);
		host.par(HI, LO, LO, HI, 8'h00, q);
		check(q, 8'hA5);
		check(8'(n_mem_rd - r), 8'h02);
		check(8'(data_oe), 8'h00);
	endtask : t_6800

	// 8080 in both strobe forms
	task automatic t_8080;
		logic [7:0] q;
		int w;
		host_port_select = 3'h6;
		host.idle(LO, LO);
		host.gap(8);
		host.par(LO, LO, HI, LO, 8'h81, q);
		host.par(LO, LO, HI, LO, 8'h3C, q);
		check(8'(contrast), 8'h3C);
		host.par(LO, HI, HI, LO, 8'hA1, q);
		host.par(LO, HI, HI, LO, 8'h05, q);
		check(8'(start_line), 8'h05);
		host.par(LO, LO, HI, LO, 8'h15, q);
		host.par(LO, LO, HI, LO, 8'h02, q);
		host.par(LO, LO, HI, LO, 8'h03, q);
		check(8'(col_addr), 8'h02);
		host.par(LO, LO, HI, HI, 8'h11, q);
		check(8'(col_addr), 8'h03);
		host.par(LO, LO, HI, HI, 8'h22, q);
		check(8'(col_addr), 8'h02);
		status = 8'h69;
		host.par(LO, LO, LO, LO, 8'h00, q);
		check(q, 8'h69);
		w = n_mem_wr;
		host.par(LO, HI, HI, HI, 8'hC7, q);
		check(last_mem, 8'hC7);
		host.par(LO, HI, LO, HI, 8'h00, q); // Dummy read shows the older fetch
		check(q, 8'hA5);
		host.par(LO, HI, LO, HI, 8'h00, q);
		check(q, 8'hC7);
		check(8'(n_mem_wr - w), 8'h01);
	endtask : t_8080

	// Serial: dropped partial byte, data byte, command byte
	task automatic t_serial;
		int w;
		host_port_select = 3'h0;
		host.idle(LO, HI);
		host.gap(8);
		w = n_mem_wr;
		host.ser(HI, 8'hFF, 3);
		host.ser(HI, 8'h96, 8);
		check(last_mem, 8'h96);
		check(8'(n_mem_wr - w), 8'h01);
		host.ser(LO, 8'hAE, 8);
		check(cmd_byte, 8'hAE);
		check(8'(display_on), 8'h00);
		check(8'(data_oe), 8'h00);
	endtask : t_serial

	// Watchdog
	initial begin
		repeat (20000) @(posedge mclk);
		mismatches++;
		$display("[ERR] %0t timeout", $time);
		results;
	end

	// Main sequence
	initial begin
		rst_b = 1'b0;
		host_port_select = 3'h6;
		status = 8'h96;
		last_mem = 8'h00;
		mismatches = 0;
		n_checks = 0;
		n_mem_wr = 0;
		n_cmd_wr = 0;
		n_mem_rd = 0;
		t_reset;
		t_modes;
		t_6800;
		t_8080;
		t_serial;
		t_reset; // Second reset after settings changed
		results;
	end
endmodule : display_host_interface_bench
